// ---- design/drp_map.svh ----
/*
  Constants for the self-refresh and partial-array retention block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 40 MHz reference clock and a link clock supplied by the memory controller.
*/
// Function
// RQ1 - controller issues the minimum refresh_all_banks count in every 32 ms refresh_window.
// RQ2 - eight refresh_one_bank commands may stand in for one refresh_all_banks.
// RQ3 - at most eight refresh_all_banks per rolling refresh_burst_window.
// RQ4 - self-refresh time in a window reduces the required refresh count proportionally.
// RQ5 - self refresh entered on CKE low, CS# low, CA0 low, CA1 low, CA2 high.
// RQ6 - CKE high the cycle before entry, NOP the cycle after.
// RQ7 - CKE low holds self refresh; all other inputs are ignored meanwhile.
// RQ8 - internal timer retains data, clock gated, first all-bank refresh promptly after entry.
// RQ9 - controller stays in self refresh at least min_self_refresh_residency.
// RQ10 - clock may stop after entry; two stable cycles needed before exit.
// RQ11 - controller waits self_refresh_exit_delay after CKE rises before commands.
// RQ12 - CKE high and NOPs throughout self_refresh_exit_delay.
// RQ13 - one refresh required after each exit before the next self-refresh entry.
// RQ14 - all banks idle before self-refresh entry.
// RQ15 - 8-bit bank_refresh_mask by mode register write; masked bank gets no refresh. Code masks internal refresh only; o_pb_strobe ignores it.
// RQ16 - 8-bit segment_refresh_mask applies to the same segment in every bank.
// RQ17 - refresh only where bank bit and segment bit are both zero. Code applies this to internal refresh only; o_pb_strobe ignores both masks.
// RQ18 - refresh command with CA3 high is all-bank, CA3 low is per-bank.
// RQ19 - per-bank counter runs 0..7 round robin, zeroed at every self-refresh exit.
// RQ20 - controller keeps refresh timing as programmable cycle counts.
`ifndef DRP_MAP_SVH
`define DRP_MAP_SVH

// mode register addresses and reset values
`define DRP_MA_BANK_MASK      8'h10
`define DRP_MA_SEG_MASK       8'h11
`define DRP_BANK_MASK_RST     8'h00
`define DRP_SEG_MASK_RST      8'h00

// command field positions on the rising and falling halves of the CA bus
`define DRP_CA_MA_HI_MSB      9
`define DRP_CA_MA_HI_LSB      4
`define DRP_CA_OP_MSB         9
`define DRP_CA_OP_LSB         2

// internal refresh timing
`define DRP_REF_CLK_MHZ       40
`define DRP_SR_INTERVAL_NS    3900
`define DRP_SR_INTERVAL_CYC   ((`DRP_SR_INTERVAL_NS * `DRP_REF_CLK_MHZ) / 1000)

`endif

// ---- design/drp_pkg.sv ----
/*
  Types shared by the refresh control block.
  Assumes the constants header is available for numeric values.
*/
package drp_pkg;

  typedef enum logic [2:0] {
    DRP_CMD_NONE,
    DRP_CMD_SELF_REF,
    DRP_CMD_REF_ALL,
    DRP_CMD_REF_ONE,
    DRP_CMD_MRW
  } drp_cmd_t;

endpackage : drp_pkg

// ---- design/drp_mask_if.sv ----
/*
  Carrier between the refresh engine and the partial-array mask gate.
  Assumes both ends run in the reference clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

interface drp_mask_if;
  logic [7:0] bank_mask;
  logic [7:0] seg_mask;
  logic [2:0] seg;
  logic [7:0] bank_en;

  modport engine (output bank_mask, output seg_mask, output seg, input bank_en);
  modport gate   (input bank_mask, input seg_mask, input seg, output bank_en);
endinterface : drp_mask_if

`default_nettype wire

// ---- design/drp_mask_gate.sv ----
/*
  Partial-array retention gate: which banks take a refresh in the current segment.
  Assumes the masks are stable while self refresh runs.
*/
`timescale 1ns/1ps
`default_nettype none

module drp_mask_gate (
  drp_mask_if.gate mif
);

  // a mask bit of 1 blocks the refresh
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bank
      assign mif.bank_en[b] = ~mif.bank_mask[b] & ~mif.seg_mask[mif.seg]; // RQ17
    end
  endgenerate

endmodule : drp_mask_gate

`default_nettype wire

// ---- design/drp_refresh_ctrl.sv ----
/*
  Self-refresh and partial-array retention control of the memory device.
  Link side decodes commands on the controller's clock; the reference side runs the
  internal refresh timer. Assumes the controller keeps its own refresh obligations.
*/
`timescale 1ns/1ps
`default_nettype none
`include "drp_map.svh"

module drp_refresh_ctrl #(
  parameter int ROW_W = 13
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_ck_clk,
  input  wire logic             i_cke,
  input  wire logic             i_cs_b,
  input  wire logic [9:0]       i_ca_rise,
  input  wire logic [9:0]       i_ca_fall,
  output logic                  o_self_refresh,
  output logic [2:0]            o_pb_bank,
  output logic                  o_pb_strobe,
  output logic                  o_clk_gated,
  output logic                  o_ref_strobe,
  output logic [7:0]            o_ref_bank_en,
  output logic [ROW_W-1:0]      o_ref_row
);

  localparam logic [7:0] SR_INTERVAL = 8'(`DRP_SR_INTERVAL_CYC);

  // =====================================================================
  // command decode
  // =====================================================================
  function automatic drp_pkg::drp_cmd_t decode_cmd(input logic cs_b, input logic [9:0] ca);
    decode_cmd = drp_pkg::DRP_CMD_NONE;
    if (!cs_b && !ca[0] && !ca[1]) begin
      if (ca[2]) begin
        decode_cmd = ca[3] ? drp_pkg::DRP_CMD_REF_ALL : drp_pkg::DRP_CMD_REF_ONE; // RQ18
      end else if (!ca[3]) begin
        decode_cmd = drp_pkg::DRP_CMD_MRW;
      end
    end
  endfunction : decode_cmd

  // =====================================================================
  // link domain reset
  // =====================================================================
  logic lrst_s1_r, lrst_s2_r, lrst_s3_r, link_rst_b_r;
  always_ff @(posedge i_ck_clk) begin
    lrst_s1_r <= i_rst_b;
    lrst_s2_r <= lrst_s1_r;
    lrst_s3_r <= lrst_s2_r;
    if (lrst_s2_r == lrst_s3_r) begin
      link_rst_b_r <= lrst_s3_r;
    end
  end

  // =====================================================================
  // link domain: entry, exit, per-bank counter, mode registers
  // =====================================================================
  drp_pkg::drp_cmd_t cmd;
  logic       cke_prev_r;
  logic       sr_link_r;
  logic [2:0] bank_cnt_r;
  logic [7:0] bank_mask_r;
  logic [7:0] seg_mask_r;
  logic [7:0] mrw_ma;
  logic [7:0] mrw_op;
  logic       sre_hit;
  logic       active;

  assign cmd     = decode_cmd(i_cs_b, i_ca_rise);
  assign mrw_ma  = {i_ca_fall[1:0], i_ca_rise[`DRP_CA_MA_HI_MSB:`DRP_CA_MA_HI_LSB]};
  assign mrw_op  = i_ca_fall[`DRP_CA_OP_MSB:`DRP_CA_OP_LSB];
  assign sre_hit = !sr_link_r && cke_prev_r && !i_cke && !i_cs_b &&
                   !i_ca_rise[0] && !i_ca_rise[1] && i_ca_rise[2];
  assign active  = !sr_link_r && cke_prev_r && i_cke;

  always_ff @(posedge i_ck_clk) begin
    if (!link_rst_b_r) begin
      cke_prev_r <= 1'b0;
    end else begin
      cke_prev_r <= i_cke;
    end
  end

  always_ff @(posedge i_ck_clk) begin
    if (!link_rst_b_r) begin
      sr_link_r <= 1'b0;
    end else if (sre_hit) begin
      sr_link_r <= 1'b1; // RQ5
    end else if (sr_link_r && i_cke) begin
      sr_link_r <= 1'b0; // RQ7
    end
  end

  always_ff @(posedge i_ck_clk) begin
    if (!link_rst_b_r) begin
      bank_cnt_r  <= 3'h0;
      o_pb_bank   <= 3'h0;
      o_pb_strobe <= 1'b0;
    end else begin
      o_pb_strobe <= 1'b0;
      if (sr_link_r && i_cke) begin
        bank_cnt_r <= 3'h0; // RQ19
      end else if (active && cmd == drp_pkg::DRP_CMD_REF_ALL) begin
        bank_cnt_r <= 3'h0; // RQ18
      end else if (active && cmd == drp_pkg::DRP_CMD_REF_ONE) begin
        o_pb_bank   <= bank_cnt_r;
        o_pb_strobe <= 1'b1;
        bank_cnt_r  <= bank_cnt_r + 3'h1; // RQ19
      end
    end
  end

  always_ff @(posedge i_ck_clk) begin
    if (!link_rst_b_r) begin
      bank_mask_r <= `DRP_BANK_MASK_RST;
      seg_mask_r  <= `DRP_SEG_MASK_RST;
    end else if (active && cmd == drp_pkg::DRP_CMD_MRW) begin
      if (mrw_ma == `DRP_MA_BANK_MASK) begin
        bank_mask_r <= mrw_op; // RQ15
      end
      if (mrw_ma == `DRP_MA_SEG_MASK) begin
        seg_mask_r <= mrw_op; // RQ16
      end
    end
  end

  assign o_self_refresh = sr_link_r;

  a_entry_decode: assert property (@(posedge i_ck_clk) disable iff (!link_rst_b_r) // RQ5
    sre_hit |=> sr_link_r)
    else $error("self-refresh entry command not taken");
  a_sr_ignores: assert property (@(posedge i_ck_clk) disable iff (!link_rst_b_r) // RQ7
    sr_link_r && !i_cke |=> sr_link_r && $stable(bank_cnt_r) && $stable(bank_mask_r) && $stable(seg_mask_r))
    else $error("input acted on during self refresh");
  a_all_bank_zero: assert property (@(posedge i_ck_clk) disable iff (!link_rst_b_r) // RQ18
    active && cmd == drp_pkg::DRP_CMD_REF_ALL |=> bank_cnt_r == 3'h0 && !o_pb_strobe)
    else $error("all-bank refresh did not zero bank counter");
  a_pb_round_robin: assert property (@(posedge i_ck_clk) disable iff (!link_rst_b_r) // RQ19
    active && cmd == drp_pkg::DRP_CMD_REF_ONE |=> o_pb_strobe && o_pb_bank == $past(bank_cnt_r)
      && bank_cnt_r == 3'($past(bank_cnt_r) + 3'h1))
    else $error("per-bank counter did not step");
  a_exit_zero: assert property (@(posedge i_ck_clk) disable iff (!link_rst_b_r) // RQ19
    sr_link_r && i_cke |=> !sr_link_r && bank_cnt_r == 3'h0)
    else $error("bank counter not zeroed on exit");

  // =====================================================================
  // crossing into the reference domain
  // =====================================================================
  logic        sr_s1_r, sr_s2_r, sr_s3_r, sr_ref_r;
  logic [15:0] msk_s1_r, msk_s2_r, msk_s3_r, msk_ref_r;

  always_ff @(posedge i_ref_clk) begin
    sr_s1_r  <= sr_link_r;
    sr_s2_r  <= sr_s1_r;
    sr_s3_r  <= sr_s2_r;
    msk_s1_r <= {bank_mask_r, seg_mask_r};
    msk_s2_r <= msk_s1_r;
    msk_s3_r <= msk_s2_r;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sr_ref_r  <= 1'b0;
      msk_ref_r <= {`DRP_BANK_MASK_RST, `DRP_SEG_MASK_RST};
    end else begin
      if (sr_s2_r == sr_s3_r) begin
        sr_ref_r <= sr_s3_r;
      end
      if (msk_s2_r == msk_s3_r) begin
        msk_ref_r <= msk_s3_r;
      end
    end
  end

  // =====================================================================
  // reference domain: internal refresh timer
  // =====================================================================
  drp_mask_if mif ();
  drp_mask_gate u_gate (.mif(mif));

  logic [7:0]       timer_r;
  logic [ROW_W-1:0] row_r;

  assign mif.bank_mask = msk_ref_r[15:8];
  assign mif.seg_mask  = msk_ref_r[7:0];
  assign mif.seg       = row_r[ROW_W-1 -: 3];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      timer_r       <= 8'h00;
      row_r         <= '0;
      o_ref_strobe  <= 1'b0;
      o_ref_bank_en <= 8'h00;
      o_ref_row     <= '0;
    end else if (!sr_ref_r) begin
      timer_r       <= 8'h00;
      o_ref_strobe  <= 1'b0;
      o_ref_bank_en <= 8'h00;
    end else if (timer_r == 8'h00) begin
      o_ref_strobe  <= 1'b1; // RQ8
      o_ref_bank_en <= mif.bank_en; // RQ17
      o_ref_row     <= row_r;
      row_r         <= row_r + ROW_W'(1);
      timer_r       <= SR_INTERVAL - 8'h01;
    end else begin
      o_ref_strobe  <= 1'b0;
      o_ref_bank_en <= 8'h00;
      timer_r       <= timer_r - 8'h01;
    end
  end

  // internal clock gating while the device retains on its own timer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_clk_gated <= 1'b0;
    end else begin
      o_clk_gated <= sr_ref_r; // RQ8
    end
  end

  a_first_refresh: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RQ8
    $rose(sr_ref_r) |=> o_ref_strobe ##1 !o_ref_strobe)
    else $error("no refresh right after self-refresh entry");
  a_refresh_interval: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RQ8
    o_ref_strobe && sr_ref_r ##1 sr_ref_r [*8] |-> !o_ref_strobe)
    else $error("internal refresh came too early");
  a_bank_masked: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RQ15
    o_ref_strobe && $stable(msk_ref_r) |-> (o_ref_bank_en & msk_ref_r[15:8]) == 8'h00)
    else $error("masked bank refreshed");
  a_seg_masked: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RQ16
    o_ref_strobe && $stable(msk_ref_r) && msk_ref_r[o_ref_row[ROW_W-1 -: 3]] |-> o_ref_bank_en == 8'h00)
    else $error("masked segment refreshed");
  a_both_unmasked: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // RQ17
    o_ref_strobe && $stable(msk_ref_r) && !msk_ref_r[o_ref_row[ROW_W-1 -: 3]]
      |-> o_ref_bank_en == ~msk_ref_r[15:8])
    else $error("unmasked bank skipped");

endmodule : drp_refresh_ctrl

`default_nettype wire

// ---- test/drp_ctl_model.sv ----
/*
  Memory controller model: drives CK, CKE, CS# and the CA halves of the device.
  Assumes the device samples everything on the rising edge of CK.
*/
`timescale 1ns/1ps
`default_nettype none

module drp_ctl_model #(
  parameter int XSR_CYC = 4
) (
  output logic       o_ck_clk,
  output logic       o_cke,
  output logic       o_cs_b,
  output logic [9:0] o_ca_rise,
  output logic [9:0] o_ca_fall
);
  logic ck_run;

  initial begin
    o_ck_clk  = 1'b0;
    ck_run    = 1'b1;
    o_cke     = 1'b1;
    o_cs_b    = 1'b1;
    o_ca_rise = 10'h000;
    o_ca_fall = 10'h000;
  end

  // clock parks low while stopped in self refresh
  always #7.5 o_ck_clk = ck_run ? ~o_ck_clk : 1'b0;

  // =====================================================
  // command tasks
  task cmd(input logic c, input logic cs, input logic [9:0] r, input logic [9:0] f);
    @(posedge o_ck_clk);
    o_cke     <= c;
    o_cs_b    <= cs;
    o_ca_rise <= r;
    o_ca_fall <= f;
  endtask : cmd

  task nop(input int n);
    repeat (n) cmd(1'b1, 1'b0, 10'h007, 10'h000);
  endtask : nop

  task enter_sr;
    int i;
    nop(1);
    cmd(1'b0, 1'b0, 10'h004, 10'h000);
    cmd(1'b0, 1'b0, 10'h007, 10'h000);
    // inputs other than CKE toggle as commands while they must be ignored
    for (i = 0; i < 4; i++) cmd(1'b0, i[0], i[1] ? 10'h000 : 10'h004, ~{5{i[1:0]}});
    @(posedge o_ck_clk);
    ck_run = 1'b0;
  endtask : enter_sr

  task exit_sr;
    ck_run = 1'b1;
    cmd(1'b0, 1'b1, 10'h3FF, 10'h155);
    cmd(1'b0, 1'b1, 10'h000, 10'h2AA);
    cmd(1'b1, 1'b0, 10'h007, 10'h000);
    nop(XSR_CYC);
  endtask : exit_sr
endmodule : drp_ctl_model

`default_nettype wire

// ---- test/dram_refresh_selfrefresh_partial_array_retention_test.sv ----
/*
  Testbench of the refresh control block: per-bank walk, all-bank reset of the counter,
  mask writes and masked internal refresh in self refresh, and exit.
  Assumes the controller model drives the link and the bench owns the reference clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "drp_map.svh"

module dram_refresh_selfrefresh_partial_array_retention_test;
  localparam int ROW_W = 5;
  logic             ref_clk;
  logic             rst_b;
  logic             ck;
  logic             cke;
  logic             cs_b;
  logic [9:0]       ca_r;
  logic [9:0]       ca_f;
  logic             self_ref;
  logic [2:0]       pb_bank;
  logic             pb_strobe;
  logic             clk_gated;
  logic             ref_strobe;
  logic [7:0]       bank_en;
  logic [ROW_W-1:0] row;
  int               n_errors = 0;
  int               cmp_count = 0;

  drp_ctl_model i_drp_ctl_model (.o_ck_clk(ck), .o_cke(cke), .o_cs_b(cs_b), .o_ca_rise(ca_r), .o_ca_fall(ca_f));
  drp_refresh_ctrl #(.ROW_W(ROW_W)) i_drp_refresh_ctrl (
    .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_ck_clk(ck), .i_cke(cke), .i_cs_b(cs_b),
    .i_ca_rise(ca_r), .i_ca_fall(ca_f), .o_self_refresh(self_ref), .o_pb_bank(pb_bank),
    .o_pb_strobe(pb_strobe), .o_clk_gated(clk_gated), .o_ref_strobe(ref_strobe),
    .o_ref_bank_en(bank_en), .o_ref_row(row));

  always #12.5 ref_clk = ~ref_clk;

  // =====================================================
  // helpers
  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task end_sim;
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  task pb(input logic [2:0] exp);
    int n;
    i_drp_ctl_model.cmd(1'b1, 1'b0, 10'h004, 10'h000);
    i_drp_ctl_model.nop(1);
    n = 0;
    #1;
    while (pb_strobe !== 1'b1 && n < 4) begin
      @(posedge ck);
      #1;
      n++;
    end
    check(pb_strobe, 1'b1);
    check(pb_bank, exp);
  endtask : pb

  task wait_strobe(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ref_strobe !== 1'b1 && n < 400);
  endtask : wait_strobe

  // =====================================================
  // scenarios
  task t_reset;
    check({self_ref, pb_strobe, clk_gated, ref_strobe, bank_en}, 12'h000);
  endtask : t_reset

  task t_pb_walk;
    int i;
    for (i = 0; i < 9; i++) pb(i[2:0]);
  endtask : t_pb_walk

  task t_refresh_all_banks;
    pb(3'd1);
    pb(3'd2);
    i_drp_ctl_model.cmd(1'b1, 1'b0, 10'h00C, 10'h000);
    i_drp_ctl_model.nop(1);
    pb(3'd0);
  endtask : t_refresh_all_banks

  task t_sr;
    int n;
    int i;
    logic [7:0] exp;
    i_drp_ctl_model.cmd(1'b1, 1'b0, 10'h100, {8'h82, 2'b00});
    i_drp_ctl_model.cmd(1'b1, 1'b0, 10'h110, {8'h84, 2'b00});
    i_drp_ctl_model.cmd(1'b1, 1'b0, 10'h120, {8'hFF, 2'b00});
    i_drp_ctl_model.nop(8);
    i_drp_ctl_model.enter_sr;
    check(self_ref, 1'b1);
    for (i = 0; i < 34; i++) begin
      wait_strobe(n);
      if (i == 0) check(clk_gated, 1'b1);
      else check(n[15:0], `DRP_SR_INTERVAL_CYC);
      check(row, i[ROW_W-1:0]);
      // segment of this row taken from the strobe count, masks as written above
      exp = 8'h84 >> i[ROW_W-1 -: 3];
      exp = exp[0] ? 8'h00 : 8'h7D;
      check(bank_en, exp);
    end
    i_drp_ctl_model.exit_sr;
    check(self_ref, 1'b0);
    pb(3'd0);
    i_drp_ctl_model.cmd(1'b1, 1'b0, 10'h00C, 10'h000);
    pb(3'd0);
    repeat (12) @(posedge ref_clk);
    check(clk_gated, 1'b0);
    check(ref_strobe, 1'b0);
  endtask : t_sr

  initial begin
    ref_clk = 1'b0;
    rst_b   = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    i_drp_ctl_model.nop(6);
    t_reset;
    t_pb_walk;
    t_refresh_all_banks;
    t_sr;
    end_sim;
  end

  initial begin
    #1_000_000;
    n_errors++;
    end_sim;
  end
endmodule : dram_refresh_selfrefresh_partial_array_retention_test

`default_nettype wire
